// [hw/pphy_port.sv]
// Controller-side parallel port of the serial transceiver.
// Assumes lane-side symbol core on CLOCK; controller pins are asynchronous.
//
// Contract
// - Transmit-idle high keeps the serial transmitter in electrical idle.
// - In P0 with idle low, controller transmit symbols are sent.
// - Compliance high forces the transmit running disparity negative.
// - Detect/loopback request starts receiver detection or loopback.
// - Strap low at reset release: single rate, sixteen bits on rising edge.
// - Strap high: double rate, low byte and flag 0 on both edges.
// - Single rate: earlier symbol on low byte, later on high byte.
// - Double rate: earlier symbol at rising edge, later at falling edge.
// - Single rate: flag 0 qualifies low byte, flag 1 high byte.
// - Double rate: flag 0 qualifies same-phase low byte; flag 1 unused.
// - Flag is 0 for a data symbol, 1 for a control symbol.
// - Receive output clock is the internal parallel-interface clock.
// - Three-bit receive status reports ok, skips, detect and errors.
// - Receive-valid shows symbol lock and valid receive data.
`timescale 1ns/1ps
module pphy_port
    import pphy_pkg::*;
#(
    parameter int SYM_DIV = SYM_DIV_DEF
)
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    // Controller transmit pins
    input  wire logic        TRANSMIT_IDLE_FORCE,
    input  wire logic [1:0]  POWER_STATE_SELECT,
    input  wire logic        TRANSMIT_COMPLIANCE,
    input  wire logic        DETECT_OR_LOOPBACK_REQUEST,
    input  wire logic [15:0] TRANSMIT_SYMBOL_LINES,
    input  wire logic [1:0]  TRANSMIT_CONTROL_FLAGS,
    input  wire logic        RATE_SELECT_STRAP,
    // Controller receive pins
    output logic             RECEIVE_CLOCK,
    output logic [15:0]      RECEIVE_SYMBOL_LINES,
    output logic [1:0]       RECEIVE_CONTROL_FLAGS,
    output logic [2:0]       RECEIVE_STATUS,
    output logic             RECEIVE_VALID,
    output logic             PHY_STATUS,
    // Lane receive side
    input  wire logic [7:0]  LANE_RX_SYMBOL,
    input  wire logic        LANE_RX_K,
    input  wire logic [2:0]  LANE_RX_STATUS,
    input  wire logic        LANE_RX_LOCK,
    input  wire logic        LANE_DETECT_DONE,
    input  wire logic        LANE_DETECT_FOUND,
    // Lane transmit side
    output logic [7:0]       LANE_TX_SYMBOL,
    output logic             LANE_TX_K,
    output logic             LANE_TX_STROBE,
    output logic             LANE_TX_ELEC_IDLE,
    output logic             LANE_TX_FORCE_NEG,
    output logic             LANE_DETECT_START,
    output logic             LANE_LOOPBACK,
    // Register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WRITE,
    input  wire logic        REG_READ,
    output logic [31:0]      REG_RDATA,
    output logic             IRQ
);
    localparam int DIV_W = $clog2(SYM_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SYM_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_MID  = DIV_W'(SYM_DIV / 2);
    localparam int SYNC_W = 24;

    generate
        if (SYM_DIV < 2 || (SYM_DIV % 2) != 0)
        begin : g_bad_div
            $error("SYM_DIV must be even and at least 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and strap capture

    logic [SYNC_W-1:0] sync_q;
    logic              s_idle;
    logic [1:0]        s_pwr;
    logic              s_comp;
    logic              s_req;
    logic [15:0]       s_txd;
    logic [1:0]        s_txk;
    logic              s_strap;
    logic              was_rst;
    logic              ddr_mode;

    pphy_sync #(.W(SYNC_W)) u_sync (
        .clk (CLOCK),
        .d   ({TRANSMIT_IDLE_FORCE, POWER_STATE_SELECT, TRANSMIT_COMPLIANCE,
               DETECT_OR_LOOPBACK_REQUEST, TRANSMIT_SYMBOL_LINES,
               TRANSMIT_CONTROL_FLAGS, RATE_SELECT_STRAP}),
        .q   (sync_q)
    );

    assign {s_idle, s_pwr, s_comp, s_req, s_txd, s_txk, s_strap} = sync_q;

    always_ff @(posedge CLOCK)
    begin
        was_rst <= SYS_RST;
    end

    // Caught on the first edge after release, then frozen
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            ddr_mode <= 1'b0;
        else if (was_rst)
            ddr_mode <= s_strap;
    end

    ////////////////////////////////////////////////////////////////////////
    // Symbol slot divider and parallel clock

    logic [DIV_W-1:0] div_cnt;
    logic             slot;
    logic             mid;
    logic             rise;
    logic             pub;

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || div_cnt == DIV_LAST)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    assign slot = (div_cnt == '0);
    assign mid  = (div_cnt == DIV_MID);
    assign rise = slot && !RECEIVE_CLOCK;
    // Data change mid-phase so they are settled at each sampling edge
    assign pub  = mid && (ddr_mode || !RECEIVE_CLOCK);

    // Half a period per symbol; transmit sampling also keys off it
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            RECEIVE_CLOCK <= 1'b0;
        else if (slot)
            RECEIVE_CLOCK <= !RECEIVE_CLOCK;
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive path

    logic [7:0] lo_sym;
    logic [7:0] hi_sym;
    logic       lo_k;
    logic       hi_k;
    logic [2:0] lo_st;
    logic [2:0] hi_st;
    logic       lock_cap;
    logic [2:0] next_status;
    logic       det_pend;
    logic       ev_found;

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            {lo_sym, lo_k, lo_st} <= '0;
            {hi_sym, hi_k, hi_st} <= '0;
            lock_cap              <= 1'b0;
        end
        else if (slot)
        begin
            lock_cap <= LANE_RX_LOCK;
            if (rise || ddr_mode)
                {lo_sym, lo_k, lo_st} <= {LANE_RX_SYMBOL, LANE_RX_K,
                                          LANE_RX_STATUS};
            else
                {hi_sym, hi_k, hi_st} <= {LANE_RX_SYMBOL, LANE_RX_K,
                                          LANE_RX_STATUS};
        end
    end

    always_comb
    begin
        if (det_pend)
            next_status = RXS_RCVR_DET;
        else if (!ddr_mode && hi_st != RXS_OK)
            next_status = hi_st;
        else
            next_status = lo_st;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            RECEIVE_SYMBOL_LINES  <= '0;
            RECEIVE_CONTROL_FLAGS <= '0;
            RECEIVE_STATUS        <= RXS_OK;
            RECEIVE_VALID         <= 1'b0;
        end
        else if (pub)
        begin
            if (ddr_mode)
            begin
                RECEIVE_SYMBOL_LINES  <= {UNUSED_BYTE, lo_sym};
                RECEIVE_CONTROL_FLAGS <= {1'b0, lo_k};
            end
            else
            begin
                RECEIVE_SYMBOL_LINES  <= {hi_sym, lo_sym};
                RECEIVE_CONTROL_FLAGS <= {hi_k, lo_k};
            end
            RECEIVE_STATUS <= next_status;
            RECEIVE_VALID  <= lock_cap;
        end
    end

    // A detection result waits for the next publish; a new one wins
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            det_pend <= 1'b0;
        else if (ev_found)
            det_pend <= 1'b1;
        else if (pub)
            det_pend <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit path

    pphy_sym_if tx_if ();
    logic       loop_mode;

    pphy_tx_gear u_tx_gear (
        .clk      (CLOCK),
        .rst      (SYS_RST),
        .ddr_mode (ddr_mode),
        .slot     (slot),
        .rise     (rise),
        .data     (s_txd),
        .flags    (s_txk),
        .out      (tx_if.src)
    );

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            LANE_TX_SYMBOL    <= UNUSED_BYTE;
            LANE_TX_K         <= 1'b0;
            LANE_TX_STROBE    <= 1'b0;
            LANE_TX_ELEC_IDLE <= 1'b1;
            LANE_TX_FORCE_NEG <= 1'b0;
        end
        else
        begin
            LANE_TX_ELEC_IDLE <= s_idle;
            LANE_TX_FORCE_NEG <= s_comp;
            if (loop_mode)
            begin
                // Received symbols go straight back out
                LANE_TX_SYMBOL <= LANE_RX_SYMBOL;
                LANE_TX_K      <= LANE_RX_K;
                LANE_TX_STROBE <= slot && !s_idle;
            end
            else
            begin
                LANE_TX_SYMBOL <= tx_if.sym;
                LANE_TX_K      <= tx_if.k;
                LANE_TX_STROBE <= tx_if.stb && !s_idle;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detection and loopback sequencing

    pphy_op_t   op;
    logic       req_q;
    logic       req_rise;
    logic [7:0] det_timer;
    logic       det_end;

    assign req_rise  = s_req && !req_q;
    assign loop_mode = (op == OP_LOOP);
    assign det_end   = (op == OP_DETECT)
                       && (LANE_DETECT_DONE || det_timer == '0);
    assign ev_found  = (op == OP_DETECT) && LANE_DETECT_DONE
                       && LANE_DETECT_FOUND;

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            req_q <= 1'b0;
        else
            req_q <= s_req;
    end

    // Requests in P0s are ignored; the controller keeps idle there
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            op                <= OP_READY;
            det_timer         <= '0;
            LANE_DETECT_START <= 1'b0;
            LANE_LOOPBACK     <= 1'b0;
            PHY_STATUS        <= 1'b0;
        end
        else
        begin
            LANE_DETECT_START <= 1'b0;
            PHY_STATUS        <= 1'b0;
            unique case (op)
                OP_READY:
                begin
                    if (req_rise && s_pwr == PWR_P1)
                    begin
                        op                <= OP_DETECT;
                        det_timer         <= DET_WAIT_COUNT;
                        LANE_DETECT_START <= 1'b1;
                    end
                    else if (req_rise && s_pwr == PWR_P0)
                    begin
                        op            <= OP_LOOP;
                        LANE_LOOPBACK <= 1'b1;
                    end
                end
                OP_DETECT:
                begin
                    if (det_end)
                    begin
                        op         <= OP_READY;
                        PHY_STATUS <= 1'b1;
                    end
                    else
                        det_timer <= det_timer - 1'b1;
                end
                OP_LOOP:
                begin
                    if (!s_req)
                    begin
                        op            <= OP_READY;
                        LANE_LOOPBACK <= 1'b0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and interrupt

    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] irq_status;
    logic [NUM_EV-1:0] irq_enable;
    logic [NUM_EV-1:0] clr;

    always_comb
    begin
        ev              = '0;
        ev[EV_DETECT]   = det_end;
        ev[EV_RX_ERR]   = pub && next_status[RXS_ERR_BIT];
        ev[EV_LOOP]     = (op == OP_READY) && req_rise && s_pwr == PWR_P0;
        ev[EV_LOCKLOSS] = slot && lock_cap && !LANE_RX_LOCK;
    end

    assign clr = (REG_WRITE && REG_ADDR == REG_CLEAR)
                 ? REG_WDATA[NUM_EV-1:0] : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            irq_status <= '0;
        else
            irq_status <= (irq_status & ~clr) | ev;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            irq_enable <= '0;
        else if (REG_WRITE && REG_ADDR == REG_ENABLE)
            irq_enable <= REG_WDATA[NUM_EV-1:0];
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            IRQ <= 1'b0;
        else
            IRQ <= |(irq_status & irq_enable);
    end

    // Read data stand one cycle only; unmapped offsets read zero
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || !REG_READ)
            REG_RDATA <= '0;
        else
        begin
            unique case (REG_ADDR)
                REG_STATUS: REG_RDATA <= 32'(irq_status);
                REG_ENABLE: REG_RDATA <= 32'(irq_enable);
                REG_STATE:  REG_RDATA <= 32'({ddr_mode, op, s_pwr,
                                              RECEIVE_VALID});
                default:    REG_RDATA <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    localparam int DET_LIMIT  = 260;
    localparam int STAT_LIMIT = 2 * SYM_DIV + 2;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    property p_idle_hold;
        s_idle |=> LANE_TX_ELEC_IDLE && !LANE_TX_STROBE;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("transmit not idle while idle forced");

    property p_send;
        !s_idle && !loop_mode && tx_if.stb |=> LANE_TX_STROBE
            && LANE_TX_SYMBOL == $past(tx_if.sym);
    endproperty
    a_send: assert property (p_send)
        else $error("valid transmit symbol not sent");

    property p_comp;
        s_comp |=> LANE_TX_FORCE_NEG;
    endproperty
    a_comp: assert property (p_comp)
        else $error("negative disparity not forced");

    property p_det_seq;
        op == OP_READY && req_rise && s_pwr == PWR_P1
            |=> LANE_DETECT_START ##1 !LANE_DETECT_START
            ##[0:DET_LIMIT] PHY_STATUS;
    endproperty
    a_det_seq: assert property (p_det_seq)
        else $error("detection not started or never completed");

    property p_sdr_pack;
        pub && !ddr_mode |=> RECEIVE_SYMBOL_LINES
            == {$past(hi_sym), $past(lo_sym)};
    endproperty
    a_sdr_pack: assert property (p_sdr_pack)
        else $error("single rate byte order wrong");

    property p_sdr_flags;
        pub && !ddr_mode |=> RECEIVE_CONTROL_FLAGS
            == {$past(hi_k), $past(lo_k)};
    endproperty
    a_sdr_flags: assert property (p_sdr_flags)
        else $error("single rate flags misplaced");

    property p_ddr_upper;
        ddr_mode && !pub |=> RECEIVE_SYMBOL_LINES[15:8] == UNUSED_BYTE
            && !RECEIVE_CONTROL_FLAGS[1];
    endproperty
    a_ddr_upper: assert property (p_ddr_upper)
        else $error("upper byte driven in double rate");

    property p_valid;
        pub |=> RECEIVE_VALID == $past(lock_cap);
    endproperty
    a_valid: assert property (p_valid)
        else $error("receive valid does not follow lock");

    property p_strap_fixed;
        !was_rst |=> $stable(ddr_mode);
    endproperty
    a_strap_fixed: assert property (p_strap_fixed)
        else $error("rate mode changed after reset release");

    property p_clk_toggle;
        slot |=> RECEIVE_CLOCK != $past(RECEIVE_CLOCK);
    endproperty
    a_clk_toggle: assert property (p_clk_toggle)
        else $error("parallel clock missed a toggle");

    property p_det_status;
        ev_found |-> ##[1:STAT_LIMIT] RECEIVE_STATUS == RXS_RCVR_DET;
    endproperty
    a_det_status: assert property (p_det_status)
        else $error("receiver detected status not reported");

    c_detect: cover property (ev_found ##[1:STAT_LIMIT] PHY_STATUS);
    c_loop:   cover property (op == OP_LOOP ##1 op == OP_READY);
    c_ddr:    cover property (ddr_mode && pub && RECEIVE_VALID);
    c_irq:    cover property (IRQ && REG_WRITE && REG_ADDR == REG_CLEAR);
endmodule

// [hw/pphy_pkg.sv]
// Package for the parallel controller-side port of the serial transceiver.
// Assumes a single 20 MHz system clock; shared by the port top and the transmit gearbox.
package pphy_pkg;

    // Clock and timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int SYM_DIV_DEF   = 4;
    // Longest wait for the lane to finish receiver detection
    localparam int DET_WAIT_NS   = 1000;
    localparam logic [7:0] DET_WAIT_COUNT = 8'(DET_WAIT_NS / CLK_PERIOD_NS);

    // Power state selection
    localparam logic [1:0] PWR_P0  = 2'h0;
    localparam logic [1:0] PWR_P0S = 2'h1;
    localparam logic [1:0] PWR_P1  = 2'h2;

    // Receive status encoding
    localparam logic [2:0] RXS_OK        = 3'h0;
    localparam logic [2:0] RXS_SKP_ADD   = 3'h1;
    localparam logic [2:0] RXS_SKP_DROP  = 3'h2;
    localparam logic [2:0] RXS_RCVR_DET  = 3'h3;
    localparam logic [2:0] RXS_DECODE    = 3'h4;
    localparam logic [2:0] RXS_OVERFLOW  = 3'h5;
    localparam logic [2:0] RXS_UNDERFLOW = 3'h6;
    localparam logic [2:0] RXS_DISPARITY = 3'h7;
    localparam int RXS_ERR_BIT = 2;

    localparam logic [7:0] UNUSED_BYTE = 8'h00;

    // Register map
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CLEAR  = 4'h4;
    localparam logic [3:0] REG_ENABLE = 4'h8;
    localparam logic [3:0] REG_STATE  = 4'hc;

    // Event bits of status, clear and enable
    localparam int EV_DETECT   = 0;
    localparam int EV_RX_ERR   = 1;
    localparam int EV_LOOP     = 2;
    localparam int EV_LOCKLOSS = 3;
    localparam int NUM_EV      = 4;

    typedef enum logic [1:0] {OP_READY, OP_DETECT, OP_LOOP} pphy_op_t;

endpackage

// [hw/pphy_sym_if.sv]
// Symbol stream between the transmit gearbox and the port top.
// Assumes one symbol per strobe, all on the system clock.
`timescale 1ns/1ps
interface pphy_sym_if;
    logic [7:0] sym;
    logic       k;
    logic       stb;

    modport src (output sym, output k, output stb);
    modport dst (input sym, input k, input stb);
endinterface

// [hw/pphy_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are quasi-static relative to the symbol rate.
`timescale 1ns/1ps
module pphy_sync #(
    parameter int W = 1
)
(
    // Clock
    input  wire logic         clk,
    // Pins in, synchronised out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // No reset, so straps flow through while reset is held
    always_ff @(posedge clk)
    begin
        meta <= d;
        q    <= meta;
    end
endmodule

// [hw/pphy_tx_gear.sv]
// Transmit gearbox: controller words to one lane symbol per slot.
// Assumes slot and rise pulses from the port top's clock divider.
`timescale 1ns/1ps
module pphy_tx_gear
    import pphy_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Timing and mode
    input  wire logic        ddr_mode,
    input  wire logic        slot,
    input  wire logic        rise,
    // Controller word
    input  wire logic [15:0] data,
    input  wire logic [1:0]  flags,
    // Symbol stream out
    pphy_sym_if.src          out
);

    logic [7:0] held_sym;
    logic       held_k;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out.sym  <= UNUSED_BYTE;
            out.k    <= 1'b0;
            out.stb  <= 1'b0;
            held_sym <= UNUSED_BYTE;
            held_k   <= 1'b0;
        end
        else
        begin
            out.stb <= slot;
            if (slot && (ddr_mode || rise))
            begin
                // Low byte goes first in single rate and is the only byte sent in double rate
                out.sym  <= data[7:0];
                out.k    <= flags[0];
                held_sym <= data[15:8];
                held_k   <= flags[1];
            end
            else if (slot)
            begin
                out.sym <= held_sym;
                out.k   <= held_k;
            end
        end
    end
endmodule

// [bench/pphy_ctrl_model.sv]
// Controller model: drives the port's transmit pins for the bench.
// Assumes the bench gives power state, idle wish and one word with flags.
`timescale 1ns/1ps
module pphy_ctrl_model
    import pphy_pkg::*;
(
    // Bench side
    input  wire logic [1:0]  pwr_req,
    input  wire logic        idle_req,
    input  wire logic        ddr,
    input  wire logic [17:0] word,
    // Transmit pins
    output logic             idle,
    output logic [1:0]       pwr,
    output logic [17:0]      lines
);
//////////////////////////////////////////////////////////////////////////////
    assign pwr   = pwr_req;
    // Idle never dropped outside P0
    assign idle  = idle_req | (pwr_req != PWR_P0);
    // Upper byte and flag grounded in double rate
    assign lines = ddr ? {1'b0, word[16], 8'h00, word[7:0]} : word;
endmodule

// [bench/phy_parallel_mac_port_tb.sv]
// Bench for the parallel port: controller model, lane stream, checks.
// Assumes the design files are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
`define WAITU(c, n) begin for (int w = 0; w < 300 && !(c); w++) \
    @(negedge clk); if (!(c)) begin error_cnt++; \
    $display("[FAIL] %s timeout", n); tally_and_finish(); end end
module phy_parallel_mac_port_tb
    import pphy_pkg::*;
;
    localparam int SD = 2;
    logic        clk, rclk, rvalid, phys, tx_stb, tx_k, tx_idle, tx_neg;
    logic        det_start, loopb, irq, idle, mode, last_rclk, have;
    logic        rst = 1'b1, strap = 1'b0, comp = 1'b0, req = 1'b0;
    logic        idle_req = 1'b1, lock = 1'b1, done = 1'b0, rr = 1'b0;
    logic        rw = 1'b0, rx_k = 1'b0;
    logic [1:0]  pwr_req = 2'h0, pwr, rflags;
    logic [2:0]  rstat, rx_st = 3'h0;
    logic [8:0]  exp_tx;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  rx_sym = 8'h00, tx_sym, prev;
    logic [15:0] rsym;
    logic [17:0] word = 18'h00000, lines;
    logic [31:0] wdata = 32'h0, rdata, d, seed = 32'h24370a2d;
    int          error_cnt, num_checks, stb_cnt;

    pphy_ctrl_model ctrl (.pwr_req(pwr_req), .idle_req(idle_req), .ddr(mode),
        .word(word), .idle(idle), .pwr(pwr), .lines(lines));
    pphy_port #(.SYM_DIV(SD)) dut (.CLOCK(clk), .SYS_RST(rst),
        .TRANSMIT_IDLE_FORCE(idle), .POWER_STATE_SELECT(pwr),
        .TRANSMIT_COMPLIANCE(comp), .DETECT_OR_LOOPBACK_REQUEST(req),
        .TRANSMIT_SYMBOL_LINES(lines[15:0]), .RATE_SELECT_STRAP(strap),
        .TRANSMIT_CONTROL_FLAGS(lines[17:16]), .RECEIVE_CLOCK(rclk),
        .RECEIVE_SYMBOL_LINES(rsym), .RECEIVE_CONTROL_FLAGS(rflags),
        .RECEIVE_STATUS(rstat), .RECEIVE_VALID(rvalid), .PHY_STATUS(phys),
        .LANE_RX_SYMBOL(rx_sym), .LANE_RX_K(rx_k), .LANE_RX_STATUS(rx_st),
        .LANE_RX_LOCK(lock), .LANE_DETECT_DONE(done),
        .LANE_DETECT_FOUND(done), .LANE_TX_SYMBOL(tx_sym), .LANE_TX_K(tx_k),
        .LANE_TX_STROBE(tx_stb), .LANE_TX_ELEC_IDLE(tx_idle),
        .LANE_TX_FORCE_NEG(tx_neg), .LANE_DETECT_START(det_start),
        .LANE_LOOPBACK(loopb), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WRITE(rw), .REG_READ(rr), .REG_RDATA(rdata), .IRQ(irq));
//////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic reg_acc(input logic w, input logic [3:0] a,
                           input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        rw    <= w;
        rr    <= ~w;
        @(posedge clk);
        rw    <= 1'b0;
        rr    <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic quiet(input logic [1:0] p, input logic i);
        @(posedge clk);
        pwr_req  <= p;
        idle_req <= i;
        settle(8);
        stb_cnt = 0;
        settle(20);
        `CHK("no_strobe", i | (p != PWR_P0), stb_cnt == 0)
        `CHK("elec_idle", i | (p != PWR_P0), tx_idle)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
//////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Lane symbol advances every cycle; flag copies bit 0
    always @(posedge clk)
    begin
        rx_sym <= rx_sym + 8'h01;
        rx_k   <= ~rx_sym[0];
    end
    // Later symbol is always SD counts above the earlier one
    always @(negedge clk)
    begin
        if (tx_stb === 1'b1)
        begin
            stb_cnt++;
            // With SD=2 a low-byte strobe falls in the high clock phase
            exp_tx = (mode || rclk) ? {lines[16], lines[7:0]}
                                    : {lines[17], lines[15:8]};
            `CHK("tx_sym", exp_tx, {tx_k, tx_sym})
        end
        if (rst || rvalid !== 1'b1)
            have = 1'b0;
        else if (rclk !== last_rclk && !mode && rclk === 1'b1)
        begin
            `CHK("rx_hi", 8'(rsym[7:0] + SD), rsym[15:8])
            `CHK("rx_k", {rsym[8], rsym[0]}, rflags)
        end
        else if (rclk !== last_rclk && mode)
        begin
            if (have)
                `CHK("rx_ddr", 8'(prev + SD), rsym[7:0])
            `CHK("rx_up", {UNUSED_BYTE, rsym[0]}, {rsym[15:8], rflags[0]})
            prev = rsym[7:0];
            have = 1'b1;
        end
        last_rclk = rclk;
    end
    initial
    begin
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk);
            strap <= m[0];
            rst   <= 1'b1;
            mode = m[0];
            repeat (16) @(posedge clk);
            rst   <= 1'b0;
            @(posedge clk);
            // Strap wanders after release; the mode must not follow
            strap <= ~m[0];
            word  <= 18'(xs());
            reg_acc(1'b0, REG_STATE, 32'h0);
            `CHK("ddr_mode", m[0], d[5])
            reg_acc(1'b0, 4'h2, 32'h0);
            `CHK("unmapped", 32'h0, d)
            quiet(PWR_P0, 1'b0);
            quiet(PWR_P0S, 1'b0);
            quiet(PWR_P1, 1'b0);
            quiet(PWR_P0, 1'b1);
            @(posedge clk);
            comp <= 1'b1;
            settle(6);
            `CHK("force_neg", 1'b1, tx_neg)
            @(posedge clk);
            req <= 1'b1;
            `WAITU(loopb === 1'b1, "loop")
            @(posedge clk);
            req  <= 1'b0;
            comp <= 1'b0;
            `WAITU(loopb === 1'b0, "loop_exit")
            reg_acc(1'b1, REG_ENABLE, 32'h1 << EV_DETECT);
            @(posedge clk);
            pwr_req <= PWR_P1;
            settle(4);
            @(posedge clk);
            req <= 1'b1;
            `WAITU(det_start === 1'b1, "det_start")
            @(posedge clk);
            req  <= 1'b0;
            done <= 1'b1;
            `WAITU(phys === 1'b1, "phy_status")
            `WAITU(rstat === RXS_RCVR_DET, "rx_status")
            @(posedge clk);
            done <= 1'b0;
            lock <= 1'b0;
            `WAITU(rvalid === 1'b0, "lock_loss")
            `CHK("irq", 1'b1, irq)
            @(posedge clk);
            rx_st <= RXS_DECODE;
            `WAITU(rstat === RXS_DECODE, "rx_err")
            @(posedge clk);
            rx_st <= RXS_OK;
            reg_acc(1'b0, REG_STATUS, 32'h0);
            `CHK("status", 1'b1, d[EV_DETECT])
            `CHK("err_event", 1'b1, d[EV_RX_ERR])
            reg_acc(1'b1, REG_ENABLE, 32'h0);
            reg_acc(1'b1, REG_CLEAR, 32'hf);
            `CHK("irq_mask", 1'b0, irq)
            reg_acc(1'b0, REG_STATUS, 32'h0);
            `CHK("cleared", 32'h0, d)
            reg_acc(1'b0, REG_STATE, 32'h0);
            `CHK("ddr_kept", m[0], d[5])
            @(posedge clk);
            lock <= 1'b1;
            `WAITU(rvalid === 1'b1, "relock")
            settle(40);
        end
        tally_and_finish();
    end
endmodule
